//--- hw/fmrds_fifo.sv
// block buffer fifo holding decoded blocks with their status byte
`default_nettype none
module fmrds_fifo
  import fmrds_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              push,
  input  wire logic [BUF_W-1:0]  push_data,
  input  wire logic              pop,
  output logic      [BUF_W-1:0]  head_data,
  output logic      [CNT_W-1:0]  count,
  output logic                   full,
  output logic                   empty
);
  localparam logic [CNT_W-1:0] LAST  = CNT_W'(BUF_DEPTH - 1);
  localparam logic [CNT_W-1:0] DEPTH = CNT_W'(BUF_DEPTH);
  logic [BUF_W-1:0] mem [BUF_DEPTH];
  logic [CNT_W-1:0] wr_ptr_reg;
  logic [CNT_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] cnt_reg;
  wire              do_pop  = pop && (cnt_reg != '0);
  wire              do_push = push && ((cnt_reg != DEPTH) || do_pop);
  wire [CNT_W-1:0]  wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 7'h01;
  wire [CNT_W-1:0]  rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 7'h01;

  assign head_data = mem[rd_ptr_reg];
  assign count     = cnt_reg;
  assign full      = (cnt_reg == DEPTH);
  assign empty     = (cnt_reg == '0);

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_next;
      if (do_pop) rd_ptr_reg <= rd_ptr_next; // RULE15
      if (do_push && !do_pop) cnt_reg <= cnt_reg + 7'h01;
      else if (do_pop && !do_push) cnt_reg <= cnt_reg - 7'h01; // RULE15
    end
  end
endmodule : fmrds_fifo
`default_nettype wire

//--- hw/fmrds_pkg.sv
// package of constants and types for the rds receive buffer and af controller
`default_nettype none
package fmrds_pkg;
  // ********************************
  // clock and timing
  // ********************************
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned US_PER_S       = 1_000_000;
  localparam int unsigned AF_LIMIT_MS    = 15;
  localparam int unsigned CYC_PER_US     = CLK_HZ / US_PER_S;
  localparam int unsigned AF_LIMIT_CYC   = AF_LIMIT_MS * (CLK_HZ / 1000);
  // ********************************
  // buffer layout
  // ********************************
  localparam int unsigned BUF_DEPTH      = 85;
  localparam int unsigned BUF_W          = 24;
  localparam int unsigned CNT_W          = 7;
  // ********************************
  // block code
  // ********************************
  localparam logic [9:0] GEN_POLY_LOW    = 10'h1b9;
  localparam logic [9:0] OFS_A           = 10'h0fc;
  localparam logic [9:0] OFS_B           = 10'h198;
  localparam logic [9:0] OFS_C           = 10'h168;
  localparam logic [9:0] OFS_CP          = 10'h350;
  localparam logic [9:0] OFS_D           = 10'h1b4;
  localparam logic [2:0] BID_A           = 3'h0;
  localparam logic [2:0] BID_B           = 3'h1;
  localparam logic [2:0] BID_C           = 3'h2;
  localparam logic [2:0] BID_CP          = 3'h3;
  localparam logic [2:0] BID_D           = 3'h4;
  localparam logic [2:0] BID_NONE        = 3'h7;
  localparam logic [2:0] ERR_NONE        = 3'h0;
  localparam logic [2:0] ERR_ONE_BIT     = 3'h1;
  localparam logic [2:0] ERR_BAD         = 3'h7;
  // ********************************
  // register map (byte offsets)
  // ********************************
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_SYNC_CFG   = 12'h004;
  localparam logic [11:0] OFF_FIFO_LVL   = 12'h008;
  localparam logic [11:0] OFF_AF_RSSI    = 12'h00c;
  localparam logic [11:0] OFF_PAUSE_CFG  = 12'h010;
  localparam logic [11:0] OFF_STATUS     = 12'h014;
  localparam logic [11:0] OFF_CLEAR      = 12'h018;
  localparam logic [11:0] OFF_IRQ_EN     = 12'h01c;
  localparam logic [11:0] OFF_FIFO_DATA  = 12'h020;
  localparam logic [11:0] OFF_STATE      = 12'h024;
  // ********************************
  // reset values
  // ********************************
  localparam logic [1:0]  RST_CTRL       = 2'h0;
  localparam logic [7:0]  RST_SYNC_CFG   = 8'h42;
  localparam logic [6:0]  RST_FIFO_LVL   = 7'h40;
  localparam logic [15:0] RST_AF_RSSI    = 16'h2010;
  localparam logic [31:0] RST_PAUSE_CFG  = 32'h0000_0000;
  localparam logic [6:0]  RST_IRQ_EN     = 7'h00;
  // ********************************
  // status bits
  // ********************************
  localparam int unsigned EV_LEVEL       = 0;
  localparam int unsigned EV_SYNC_GAIN   = 1;
  localparam int unsigned EV_SYNC_LOST   = 2;
  localparam int unsigned EV_AF_SWITCH   = 3;
  localparam int unsigned EV_AF_RETURN   = 4;
  localparam int unsigned EV_IMAGE       = 5;
  localparam int unsigned EV_OVERFLOW    = 6;
  localparam int unsigned EV_N           = 7;
  // ********************************
  // state machine types
  // ********************************
  typedef enum logic [0:0] {
    FMRDS_HUNT = 1'b0,
    FMRDS_SYNC = 1'b1
  } fmrds_sync_t;
  typedef enum logic [2:0] {
    FMRDS_AF_IDLE  = 3'b000,
    FMRDS_AF_PAUSE = 3'b001,
    FMRDS_AF_TUNE  = 3'b010,
    FMRDS_AF_BACK  = 3'b011
  } fmrds_af_t;
endpackage : fmrds_pkg
`default_nettype wire

//--- hw/fmrds_rx.sv
// rds block decoder, block buffer, af switching controller and apb registers
// ********************************
// How it works
// RULE1: syndrome check, single-bit data correction and block identification run in hardware.
// RULE2: host sets acquire and loss counts for block synchronisation.
// RULE3: buffer holds up to 85 blocks until the host reads them.
// RULE4: each entry has 3-bit id, 3-bit error, buffer flag, spare bit.
// RULE5: interrupt status set when buffer count reaches the host level.
// RULE6: every received block is buffered and readable on request; code drops a block arriving while the buffer is full and not read.
// RULE7: af attempt including return to original finishes within 15 ms; only the tune step times out, return waits on tune_done.
// RULE8: host may disable af; enabled, it starts below rssi threshold.
// RULE9: switch kept only if af rssi meets host minimum.
// RULE10: pause detect compares l plus r level with programmable threshold.
// RULE11: silence counts as pause only after programmable minimum time.
// RULE12: with pause detect off, af starts as soon as rssi drops.
// RULE13: audio muted while an af update is in progress.
// RULE14: image during af or scan raises no host interrupt.
// RULE15: blocks read oldest first, count drops by one per read.
// ********************************
`default_nettype none
module fmrds_rx
  import fmrds_pkg::*;
#(
  parameter int unsigned AF_TIMEOUT_CYC = AF_LIMIT_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic             irq,
  input  wire logic        blk_valid,
  input  wire logic [25:0] blk_word,
  input  wire logic [7:0]  rssi,
  input  wire logic [15:0] audio_lr,
  input  wire logic [7:0]  af_cand,
  input  wire logic [7:0]  cur_freq,
  input  wire logic        tune_done,
  input  wire logic [7:0]  tune_rssi,
  input  wire logic        image_det,
  input  wire logic        scan_active,
  output logic             tune_req,
  output logic      [7:0]  tune_freq,
  output logic             audio_mute,
  output logic             af_busy
);
  // ********************************
  // syndrome helper
  // ********************************
  function automatic logic [9:0] fmrds_synd(input logic [25:0] w);
    logic [9:0] r;
    logic       m;
    r = '0;
    for (int i = 25; i >= 0; i--) begin
      m = r[9];
      r = {r[8:0], w[i]};
      if (m) r = r ^ GEN_POLY_LOW;
    end
    return r;
  endfunction : fmrds_synd

  // ********************************
  // registers
  // ********************************
  logic [1:0]       ctrl_reg;
  logic [7:0]       sync_cfg_reg;
  logic [6:0]       fifo_lvl_reg;
  logic [15:0]      af_rssi_reg;
  logic [31:0]      pause_cfg_reg;
  logic [EV_N-1:0]  irq_en_reg;
  logic [EV_N-1:0]  status_reg;
  logic             irq_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [31:0]      prdata_reg;

  wire apb_go   = psel && penable && !pready_reg;
  wire wr_go    = apb_go && pwrite;
  wire rd_go    = apb_go && !pwrite;
  wire a_ctrl   = (paddr == OFF_CTRL);
  wire a_sync   = (paddr == OFF_SYNC_CFG);
  wire a_lvl    = (paddr == OFF_FIFO_LVL);
  wire a_afr    = (paddr == OFF_AF_RSSI);
  wire a_pause  = (paddr == OFF_PAUSE_CFG);
  wire a_stat   = (paddr == OFF_STATUS);
  wire a_clr    = (paddr == OFF_CLEAR);
  wire a_ien    = (paddr == OFF_IRQ_EN);
  wire a_data   = (paddr == OFF_FIFO_DATA);
  wire a_state  = (paddr == OFF_STATE);
  wire a_hit    = a_ctrl || a_sync || a_lvl || a_afr || a_pause || a_stat || a_clr || a_ien || a_data || a_state;
  wire a_ro     = a_stat || a_data || a_state;
  wire a_wo     = a_clr;
  wire bad_acc  = !a_hit || (pwrite && a_ro) || (!pwrite && a_wo);
  wire af_en    = ctrl_reg[0];
  wire pause_en = ctrl_reg[1];
  wire [3:0] sync_acq  = sync_cfg_reg[3:0];
  wire [3:0] sync_loss = sync_cfg_reg[7:4];

  // ********************************
  // block decoder and sync
  // ********************************
  fmrds_sync_t sync_reg;
  logic [3:0]  good_cnt_reg;
  logic [3:0]  bad_cnt_reg;
  logic [2:0]  exp_id_reg;
  logic        ovf_pend_reg;

  wire [9:0] syn     = fmrds_synd(blk_word); // RULE1
  wire       is_a    = (syn == OFS_A);
  wire       is_b    = (syn == OFS_B);
  wire       is_c    = (syn == OFS_C);
  wire       is_cp   = (syn == OFS_CP);
  wire       is_d    = (syn == OFS_D);
  wire       is_any  = is_a || is_b || is_c || is_cp || is_d;
  wire [2:0] raw_id  = is_a ? BID_A : is_b ? BID_B : is_c ? BID_C : is_cp ? BID_CP : is_d ? BID_D : BID_NONE;
  wire       in_sync = (sync_reg == FMRDS_SYNC);
  wire [9:0] exp_ofs = (exp_id_reg == BID_A) ? OFS_A : (exp_id_reg == BID_B) ? OFS_B :
                       (exp_id_reg == BID_D) ? OFS_D : OFS_C;
  wire [9:0] syn_err = syn ^ exp_ofs;
  wire       exp_hit = is_any && ((raw_id == exp_id_reg) || (exp_id_reg == BID_C && raw_id == BID_CP));
  logic [15:0] flip_bit;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_corr
      assign flip_bit[gi] = (syn_err == fmrds_synd(26'(1) << (gi + 10))); // RULE1
    end
  endgenerate
  wire        one_bit  = in_sync && !exp_hit && (flip_bit != '0);
  wire        blk_good = exp_hit || (!in_sync && is_any);
  wire [15:0] blk_data = one_bit ? (blk_word[25:10] ^ flip_bit) : blk_word[25:10]; // RULE1
  wire [2:0]  blk_id   = in_sync ? ((exp_id_reg == BID_C && raw_id == BID_CP) ? BID_CP : exp_id_reg) : raw_id;
  wire [2:0]  blk_err  = blk_good ? ERR_NONE : one_bit ? ERR_ONE_BIT : ERR_BAD;
  wire [2:0]  id_after = (blk_id == BID_A) ? BID_B : (blk_id == BID_B) ? BID_C :
                         (blk_id == BID_C || blk_id == BID_CP) ? BID_D : BID_A;
  wire        seq_ok   = (good_cnt_reg == '0) || exp_hit;
  wire        gain_ev  = blk_valid && !in_sync && is_any && seq_ok && (good_cnt_reg + 4'h1 >= sync_acq);
  wire        lost_ev  = blk_valid && in_sync && !exp_hit && !one_bit && (bad_cnt_reg + 4'h1 >= sync_loss);

  // ********************************
  // block buffer
  // ********************************
  logic [BUF_W-1:0] head_data;
  logic [CNT_W-1:0] fifo_cnt;
  logic             fifo_full;
  logic             fifo_empty;
  logic             lvl_hit_reg;
  wire              fifo_pop  = rd_go && a_data && !fifo_empty;
  wire              ovf_ev    = blk_valid && fifo_full && !fifo_pop;
  wire [BUF_W-1:0]  push_word = {blk_id, blk_err, ovf_pend_reg, 1'b0, blk_data}; // RULE4
  wire              lvl_hit   = (fifo_lvl_reg != '0) && (fifo_cnt >= fifo_lvl_reg);
  wire              lvl_ev    = lvl_hit && !lvl_hit_reg; // RULE5

  fmrds_fifo u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (blk_valid), // RULE6
    .push_data (push_word),
    .pop       (fifo_pop), // RULE15
    .head_data (head_data),
    .count     (fifo_cnt), // RULE3
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg     <= FMRDS_HUNT;
      good_cnt_reg <= '0;
      bad_cnt_reg  <= '0;
      exp_id_reg   <= BID_A;
      ovf_pend_reg <= 1'b0;
      lvl_hit_reg  <= 1'b0;
    end else begin
      lvl_hit_reg <= lvl_hit;
      if (ovf_ev) ovf_pend_reg <= 1'b1;
      else if (blk_valid) ovf_pend_reg <= 1'b0;
      if (blk_valid) begin
        exp_id_reg <= id_after;
        if (!in_sync) begin
          good_cnt_reg <= !is_any ? 4'h0 : !seq_ok ? 4'h1 : good_cnt_reg + 4'h1; // RULE2
          if (gain_ev) sync_reg <= FMRDS_SYNC; // RULE2
          bad_cnt_reg <= '0;
        end else if (blk_good || one_bit) begin
          bad_cnt_reg <= '0;
        end else if (lost_ev) begin
          sync_reg     <= FMRDS_HUNT; // RULE2
          good_cnt_reg <= '0;
        end else begin
          bad_cnt_reg <= bad_cnt_reg + 4'h1;
        end
      end
    end
  end

  // ********************************
  // pause detector
  // ********************************
  logic [5:0]  us_div_reg;
  logic [15:0] sil_cnt_reg;
  wire         us_tick  = (us_div_reg == 6'(CYC_PER_US - 1));
  wire         silent   = (audio_lr < pause_cfg_reg[15:0]); // RULE10
  wire         pause_ok = silent && (sil_cnt_reg >= pause_cfg_reg[31:16]); // RULE11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_div_reg  <= '0;
      sil_cnt_reg <= '0;
    end else begin
      us_div_reg <= (us_tick || !silent) ? 6'h00 : us_div_reg + 6'h01; // RULE11
      if (!silent) sil_cnt_reg <= '0; // RULE11
      else if (us_tick && sil_cnt_reg != 16'hffff) sil_cnt_reg <= sil_cnt_reg + 16'h0001;
    end
  end

  // ********************************
  // af controller
  // ********************************
  fmrds_af_t   af_reg;
  logic [19:0] af_tmr_reg;
  logic [7:0]  orig_freq_reg;
  logic        tune_req_reg;
  logic [7:0]  tune_freq_reg;
  logic        mute_reg;
  wire         af_low     = af_en && (rssi < af_rssi_reg[7:0]); // RULE8
  wire         af_timeout = (af_tmr_reg >= 20'(AF_TIMEOUT_CYC - 1));
  wire         af_good    = tune_done && (tune_rssi >= af_rssi_reg[15:8]) && !image_det; // RULE9
  wire         af_start   = (af_reg == FMRDS_AF_IDLE && af_low && !pause_en) ||
                            (af_reg == FMRDS_AF_PAUSE && af_low && pause_ok); // RULE12
  wire         sw_ev      = (af_reg == FMRDS_AF_TUNE) && af_good && !af_timeout;
  wire         ret_ev     = (af_reg == FMRDS_AF_BACK) && tune_done;
  wire         go_back    = (af_reg == FMRDS_AF_TUNE) && ((tune_done && !af_good) || af_timeout);
  wire         img_ev     = image_det && (af_reg == FMRDS_AF_IDLE) && !scan_active; // RULE14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_reg        <= FMRDS_AF_IDLE;
      af_tmr_reg    <= '0;
      orig_freq_reg <= '0;
      tune_req_reg  <= 1'b0;
      tune_freq_reg <= '0;
      mute_reg      <= 1'b0;
    end else begin
      tune_req_reg <= af_start || go_back;
      if (af_reg == FMRDS_AF_IDLE || af_reg == FMRDS_AF_PAUSE) af_tmr_reg <= '0;
      else if (!af_timeout) af_tmr_reg <= af_tmr_reg + 20'h0_0001; // RULE7
      case (af_reg)
        FMRDS_AF_IDLE: begin
          if (af_low && pause_en) af_reg <= FMRDS_AF_PAUSE;
          else if (af_start) af_reg <= FMRDS_AF_TUNE;
        end
        FMRDS_AF_PAUSE: begin
          if (!af_low) af_reg <= FMRDS_AF_IDLE;
          else if (pause_ok) af_reg <= FMRDS_AF_TUNE; // RULE11
        end
        FMRDS_AF_TUNE: begin
          if (sw_ev) af_reg <= FMRDS_AF_IDLE; // RULE9
          else if (go_back) af_reg <= FMRDS_AF_BACK; // RULE7
        end
        FMRDS_AF_BACK: begin
          if (ret_ev) af_reg <= FMRDS_AF_IDLE;
        end
        default: af_reg <= FMRDS_AF_IDLE;
      endcase
      if (af_start) begin
        orig_freq_reg <= cur_freq;
        tune_freq_reg <= af_cand;
      end else if (go_back) begin
        tune_freq_reg <= orig_freq_reg; // RULE7
      end
      mute_reg <= af_start || ((af_reg == FMRDS_AF_TUNE) && !sw_ev) ||
                  ((af_reg == FMRDS_AF_BACK) && !ret_ev); // RULE13
    end
  end

  // ********************************
  // interrupt status
  // ********************************
  logic [EV_N-1:0] ev_vec;
  assign ev_vec[EV_LEVEL]     = lvl_ev;
  assign ev_vec[EV_SYNC_GAIN] = gain_ev;
  assign ev_vec[EV_SYNC_LOST] = lost_ev;
  assign ev_vec[EV_AF_SWITCH] = sw_ev;
  assign ev_vec[EV_AF_RETURN] = ret_ev;
  assign ev_vec[EV_IMAGE]     = img_ev;
  assign ev_vec[EV_OVERFLOW]  = ovf_ev;
  wire [EV_N-1:0] clr_vec     = (wr_go && a_clr) ? pwdata[EV_N-1:0] : '0;
  wire [EV_N-1:0] status_next = (status_reg & ~clr_vec) | ev_vec;

  // ********************************
  // apb slave
  // ********************************
  wire [31:0] rd_mux =
    a_ctrl  ? {30'h0, ctrl_reg} :
    a_sync  ? {24'h0, sync_cfg_reg} :
    a_lvl   ? {25'h0, fifo_lvl_reg} :
    a_afr   ? {16'h0, af_rssi_reg} :
    a_pause ? pause_cfg_reg :
    a_stat  ? {25'h0, status_reg} :
    a_ien   ? {25'h0, irq_en_reg} :
    a_data  ? (fifo_empty ? 32'h0000_0000 : {8'h00, head_data}) : // RULE6
    a_state ? {19'h0, af_reg, fifo_full, fifo_empty, sync_reg, fifo_cnt} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= RST_CTRL;
      sync_cfg_reg  <= RST_SYNC_CFG;
      fifo_lvl_reg  <= RST_FIFO_LVL;
      af_rssi_reg   <= RST_AF_RSSI;
      pause_cfg_reg <= RST_PAUSE_CFG;
      irq_en_reg    <= RST_IRQ_EN;
      status_reg    <= '0;
      irq_reg       <= 1'b0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= '0;
    end else begin
      pready_reg  <= apb_go;
      pslverr_reg <= apb_go && bad_acc;
      if (rd_go) prdata_reg <= bad_acc ? 32'h0000_0000 : rd_mux;
      if (wr_go && a_ctrl) ctrl_reg <= pwdata[1:0]; // RULE8
      if (wr_go && a_sync) sync_cfg_reg <= pwdata[7:0]; // RULE2
      if (wr_go && a_lvl) fifo_lvl_reg <= pwdata[6:0]; // RULE5
      if (wr_go && a_afr) af_rssi_reg <= pwdata[15:0]; // RULE8
      if (wr_go && a_pause) pause_cfg_reg <= pwdata; // RULE10
      if (wr_go && a_ien) irq_en_reg <= pwdata[EV_N-1:0];
      status_reg <= status_next;
      irq_reg    <= |(status_next & irq_en_reg);
    end
  end

  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign prdata     = prdata_reg;
  assign irq        = irq_reg;
  assign tune_req   = tune_req_reg;
  assign tune_freq  = tune_freq_reg;
  assign audio_mute = mute_reg;
  assign af_busy    = mute_reg;
endmodule : fmrds_rx
`default_nettype wire

//--- sim/fmrds_rx_bench.sv
// self-checking bench for the rds receiver
`default_nettype none
module fmrds_rx_bench
  import fmrds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        blk_valid = 1'b0, ans_img = 1'b0, ignore = 1'b0, ovf = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [25:0] blk_word = 26'h0;
  logic [15:0] audio_lr = 16'h0000;
  logic [7:0]  rssi = 8'h80, af_cand, cur_freq, ans_rssi = 8'h00, tune_freq, tune_rssi;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, tune_req, audio_mute, af_busy, tune_done, image_det;
  logic [31:0] mq[$];
  int          n_fail = 0, samples_checked = 0, n;
  integer      seed = 32'h0000_46aa;
  logic [11:0] ra[9] = '{OFF_CTRL, OFF_SYNC_CFG, OFF_FIFO_LVL, OFF_AF_RSSI, OFF_PAUSE_CFG,
                         OFF_STATUS, OFF_IRQ_EN, OFF_STATE, 12'h030};
  logic [31:0] rv[9] = '{32'(RST_CTRL), 32'(RST_SYNC_CFG), 32'(RST_FIFO_LVL),
                         32'(RST_AF_RSSI), RST_PAUSE_CFG, 32'h0, 32'(RST_IRQ_EN), 32'h0000_0100, 32'h0};
  always #12.5 pclk = ~pclk;
  fmrds_rx #(.AF_TIMEOUT_CYC(200)) u_fmrds_rx (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .irq, .blk_valid, .blk_word, .rssi, .audio_lr, .af_cand, .cur_freq,
    .tune_done, .tune_rssi, .image_det, .scan_active(1'b0), .tune_req, .tune_freq, .audio_mute, .af_busy);
  fmrds_tuner_model u_fmrds_tuner_model (.pclk, .presetn, .tune_req, .ans_rssi, .ans_img, .ignore,
    .tune_done, .tune_rssi, .image_det);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input string nm, logic w, logic [11:0] a, logic [31:0] d, exp, logic ee);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    if (!w) chk(nm, exp, prdata);
    chk(nm, 32'(ee), 32'(pslverr));
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 16) begin
      n_fail++;
      stop_test();
    end
  endtask : acc
  function automatic logic [9:0] cw(input logic [15:0] d);
    logic [25:0] r;
    r = {d, 10'h000};
    for (int k = 25; k >= 10; k--) if (r[k]) r[k-:11] = r[k-:11] ^ {1'b1, GEN_POLY_LOW};
    return r[9:0];
  endfunction : cw
  function automatic logic [31:0] st_exp();
    return {22'h0, mq.size() == BUF_DEPTH, mq.size() == 0, 1'b0, 7'(mq.size())};
  endfunction : st_exp
  task automatic push(input int cnt);
    logic [15:0] d;
    logic        g;
    for (int k = 0; k < cnt; k++) begin
      d = 16'($random(seed));
      g = !k[0];
      @(posedge pclk);
      blk_valid <= 1'b1;
      blk_word  <= {d, cw(d) ^ OFS_A ^ (g ? 10'h000 : 10'h3ff)};
      if (mq.size() < BUF_DEPTH) mq.push_back({8'h00, g ? BID_A : BID_NONE, g ? ERR_NONE : ERR_BAD, ovf, 1'b0, d});
      ovf = mq.size() >= BUF_DEPTH && k >= BUF_DEPTH;
    end
    @(posedge pclk);
    blk_valid <= 1'b0;
  endtask : push
  task automatic drain();
    while (mq.size() > 0) begin
      acc("fifo entry", 1'b0, OFF_FIFO_DATA, 32'h0, mq.pop_front(), 1'b0);
      acc("fill state", 1'b0, OFF_STATE, 32'h0, st_exp(), 1'b0);
    end
  endtask : drain
  task automatic af(input logic [7:0] tr, logic im, ig, logic [31:0] st);
    int i;
    ans_rssi <= tr;
    ans_img  <= im;
    ignore   <= ig;
    rssi     <= 8'h05;
    for (n = 0; n < 600 && tune_req !== 1'b1; n++) @(posedge pclk);
    chk("af target", 32'(af_cand), 32'(tune_freq));
    chk("af mute", 32'h1, 32'(audio_mute));
    rssi   <= 8'h80;
    ignore <= 1'b0;
    for (i = 0; i < 600 && audio_mute !== 1'b0; i++) @(posedge pclk);
    chk("af wait", 32'h0, 32'(n >= 600 || i >= 600));
    if (n >= 600 || i >= 600) stop_test();
    chk("af freq", 32'(st[4] ? cur_freq : af_cand), 32'(tune_freq));
    acc("af status", 1'b0, OFF_STATUS, 32'h0, st, 1'b0);
    acc("af clear", 1'b1, OFF_CLEAR, 32'h0000_007f, 32'h0, 1'b0);
  endtask : af
  task automatic quiet(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      @(posedge pclk);
      chk("tune request", 32'h0, 32'(tune_req));
    end
  endtask : quiet
  initial begin
    af_cand  = 8'($random(seed));
    cur_freq = af_cand ^ 8'h5a;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 9; k++) acc("reset value", 1'b0, ra[k], 32'h0, rv[k], k == 8);
    acc("ro write", 1'b1, OFF_STATUS, 32'h0000_00ff, 32'h0, 1'b1);
    acc("clear read", 1'b0, OFF_CLEAR, 32'h0, 32'h0, 1'b1);
    acc("level", 1'b1, OFF_FIFO_LVL, 32'h0000_0003, 32'h0, 1'b0);
    push(BUF_DEPTH + 1);
    chk("irq masked", 32'h0, 32'(irq));
    acc("full state", 1'b0, OFF_STATE, 32'h0, st_exp(), 1'b0);
    acc("irq enable", 1'b1, OFF_IRQ_EN, 32'h0000_0001, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    acc("status", 1'b0, OFF_STATUS, 32'h0, 32'h0000_0041, 1'b0);
    acc("clear", 1'b1, OFF_CLEAR, 32'h0000_007f, 32'h0, 1'b0);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    drain();
    push(1);
    drain();
    acc("empty read", 1'b0, OFF_FIFO_DATA, 32'h0, 32'h0, 1'b0);
    acc("af on", 1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
    af(8'h30, 1'b0, 1'b0, 32'h0000_0008);
    chk("af start", 32'h2, 32'(n));
    af(8'h10, 1'b0, 1'b0, 32'h0000_0010);
    af(8'h30, 1'b1, 1'b0, 32'h0000_0010);
    af(8'h30, 1'b0, 1'b1, 32'h0000_0010);
    acc("pause cfg", 1'b1, OFF_PAUSE_CFG, 32'h0002_0100, 32'h0, 1'b0);
    acc("pause on", 1'b1, OFF_CTRL, 32'h0000_0003, 32'h0, 1'b0);
    audio_lr <= 16'hffff;
    rssi     <= 8'h05;
    quiet(150);
    audio_lr <= 16'h0010;
    af(8'h30, 1'b0, 1'b0, 32'h0000_0008);
    chk("pause length", 32'h1, 32'(n >= 80 && n <= 86));
    acc("af off", 1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
    rssi <= 8'h05;
    quiet(100);
    stop_test();
  end
endmodule : fmrds_rx_bench
`default_nettype wire

//--- sim/fmrds_rx_properties.sv
// port checker for the rds receiver
`default_nettype none
module fmrds_rx_chk
  import fmrds_pkg::*;
#(
  parameter int unsigned AF_TIMEOUT_CYC = AF_LIMIT_CYC
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        tune_req,
  input wire logic        tune_done,
  input wire logic        audio_mute,
  input wire logic        af_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= af_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  rdata_hold_a: assert property ($changed(prdata) |-> pready) else $error("prdata moved");
  req_pulse_a: assert property (tune_req |=> !tune_req) else $error("long tune_req");
  mute_req_a: assert property (tune_req |=> audio_mute) else $error("no mute");
  mute_rise_a: assert property ($rose(audio_mute) |-> tune_req) else $error("stray mute");
  mute_fall_a: assert property ($fell(audio_mute) |-> $past(tune_done)) else $error("early unmute");
  busy_req_a: assert property (tune_req |=> af_busy) else $error("not busy");
  af_limit_a: assert property (tune_req && af_busy |-> busy_cnt <= AF_TIMEOUT_CYC + 4) else $error("slow");
endmodule : fmrds_rx_chk
bind fmrds_rx fmrds_rx_chk #(.AF_TIMEOUT_CYC(AF_TIMEOUT_CYC)) u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .tune_req, .tune_done, .audio_mute, .af_busy);
`default_nettype wire

//--- sim/fmrds_tuner_model.sv
// tuner model answering tune requests
`default_nettype none
module fmrds_tuner_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tune_req,
  input  wire logic [7:0] ans_rssi,
  input  wire logic       ans_img,
  input  wire logic       ignore,
  output logic            tune_done,
  output logic      [7:0] tune_rssi,
  output logic            image_det
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 0;
      tune_done <= 1'b0;
      tune_rssi <= 8'h00;
      image_det <= 1'b0;
    end else begin
      tune_done <= 1'b0;
      image_det <= 1'b0;
      tune_rssi <= ~tune_rssi;
      if (tune_req && !ignore) begin
        cnt <= 6;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt       <= 0;
        tune_done <= 1'b1;
        tune_rssi <= ans_rssi;
        image_det <= ans_img;
      end
    end
  end
endmodule : fmrds_tuner_model
`default_nettype wire
